/* dbu_checker.sv */
// dbu checker: bus, exception and stall properties
`timescale 1ns/1ps
module dbu_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // bus and mode
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cpuRealMode,
    input wire logic [1:0] cpuPrivLevel,
    // pipeline
    input wire dbu_pkg::dbu_fetch_s fetchIn,
    input wire logic instRetire,
    input wire logic dataXferBusy,
    input wire logic taskSwitch,
    input wire logic switchTrapBit,
    input wire dbu_pkg::dbu_exc_s excOut,
    input wire logic stallNext
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    wire logic req = avs_read | avs_write;
    wire logic deny = !cpuRealMode && cpuPrivLevel != 2'h0;
    wire logic done = req && !avs_waitrequest;
    // ====================================================
    // properties
    a_one_wait: assert property (req && avs_waitrequest |=> done)
        else $error("bus wait not one cycle");
    a_deny_fault: assert property (done && deny |=> excOut.privFault)
        else $error("denied access without fault");
    a_deny_cause: assert property (excOut.privFault |-> $past(done && deny))
        else $error("fault without denied access");
    a_deny_zero: assert property (avs_read && done && deny |-> avs_readdata == 32'h0)
        else $error("denied read returned data");
    a_fault_cause: assert property (excOut.fault |-> $past(fetchIn.valid) || $past(req))
        else $error("fault without fetch or access");
    a_resume_quiet: assert property (fetchIn.valid && fetchIn.resume && !req |=> !excOut.fault)
        else $error("fault on resumed fetch");
    a_stall_busy: assert property (instRetire && dataXferBusy ##1 dataXferBusy |-> stallNext)
        else $error("no stall while transfers busy");
    a_trap_exact: assert property (excOut.trap |-> $past(taskSwitch, 2) || !$past(dataXferBusy))
        else $error("trap before transfers done");
    a_switch_trap: assert property (taskSwitch && switchTrapBit |-> ##2 excOut.trap)
        else $error("no trap after marked switch");
    c_fault: cover property (excOut.fault);
    c_trap: cover property (excOut.trap);
    c_stall: cover property (stallNext);
endmodule

bind dbu_debug_breakpoint_unit dbu_checker u_dbu_checker (
    .sys_clk, .resetn, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .cpuRealMode, .cpuPrivLevel, .fetchIn, .instRetire, .dataXferBusy,
    .taskSwitch, .switchTrapBit, .excOut, .stallNext
);

/* dbu_debug_breakpoint_unit.sv */
// debug breakpoint unit: address compare, exception 1 raising, debug registers
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module dbu_debug_breakpoint_unit (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // processor mode
    input wire logic cpuRealMode,
    input wire logic [1:0] cpuPrivLevel,
    // instruction start and data access, linear addresses
    input wire dbu_pkg::dbu_fetch_s fetchIn,
    input wire dbu_pkg::dbu_data_s dataIn,
    // instruction end
    input wire logic instRetire,
    input wire logic singleStepEnable,
    input wire logic dataXferBusy,
    // task switch
    input wire logic taskSwitch,
    input wire logic switchTrapBit,
    // exception requests and stall
    output dbu_pkg::dbu_exc_s excOut,
    output logic stallNext
);

    // ====================================================
    // helpers
    function automatic logic [3:0] fieldLanes(input logic [1:0] size, input logic [1:0] low);
        logic [3:0] m;
        m = 4'h0;
        unique case (size)
            dbu_pkg::SIZE_1: m = 4'h1 << low;
            dbu_pkg::SIZE_2: m = low[1] ? 4'hc : 4'h3;
            dbu_pkg::SIZE_4: m = 4'hf;
            default: m = 4'h0;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ====================================================
    // state
    logic [31:0] bpAddrReg [4];
    logic [31:0] statusReg, statusNext;
    logic [31:0] controlReg, controlNext;
    logic ackReg, ackNext;
    logic [31:0] rdataReg, rdataNext;
    logic faultReg, faultNext;
    logic trapReg, trapNext;
    logic privReg, privNext;
    logic dataPendReg, dataPendNext;
    logic stepPendReg, stepPendNext;
    logic retireWaitReg, retireWaitNext;
    logic switchPendReg, switchPendNext;

    // ====================================================
    // breakpoint compare
    wire [3:0] enabled;
    wire [3:0] instHit;
    wire [3:0] dataHit;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : gBp
            localparam int QL = dbu_pkg::CT_QUAL_LSB + gi * dbu_pkg::CT_BP_STRIDE;
            localparam int SL = dbu_pkg::CT_SIZE_LSB + gi * dbu_pkg::CT_BP_STRIDE;
            wire [1:0] qual = controlReg[QL +: 2];
            wire [1:0] size = controlReg[SL +: 2];
            wire [3:0] lanes = fieldLanes(size, bpAddrReg[gi][1:0]);
            wire qualOk = (qual == dbu_pkg::QUAL_RW) || ((qual == dbu_pkg::QUAL_WRITE) && dataIn.write);
            assign enabled[gi] = controlReg[dbu_pkg::CT_LOCAL_EN_LSB + 2*gi]
                               | controlReg[dbu_pkg::CT_GLOBAL_EN_LSB + 2*gi];
            assign instHit[gi] = fetchIn.valid && !fetchIn.resume
                               && (qual == dbu_pkg::QUAL_EXEC)
                               && (fetchIn.addr == bpAddrReg[gi]);
            assign dataHit[gi] = dataIn.valid && qualOk
                               && (dataIn.dwordAddr == bpAddrReg[gi][31:2])
                               && |(dataIn.lanes & lanes);
        end
    endgenerate

    wire instFault = |(instHit & enabled);
    wire dataEnHit = |(dataHit & enabled);
    wire anyEnHit = instFault | dataEnHit;
    wire [3:0] hitSet = anyEnHit ? (instHit | dataHit) : 4'h0;

    // ====================================================
    // instruction end and traps
    wire retireNow = instRetire | retireWaitReg;
    wire trapDue = retireNow & ~dataXferBusy;
    wire stepNow = instRetire & singleStepEnable;
    wire dataTrapFire = trapDue & (dataPendReg | dataEnHit);
    wire stepTrapFire = trapDue & (stepPendReg | stepNow);
    wire switchTrapFire = switchPendReg;
    wire trapFire = dataTrapFire | stepTrapFire | switchTrapFire;

    assign retireWaitNext = retireNow & dataXferBusy;
    assign stepPendNext = (stepPendReg | stepNow) & ~trapDue;
    assign dataPendNext = dataEnHit | (dataPendReg & ~trapDue);
    assign switchPendNext = taskSwitch & switchTrapBit;
    assign stallNext = retireWaitNext;

    // ====================================================
    // bus decode
    wire busReq = avs_read | avs_write;
    wire busAct = busReq & ackReg;
    wire [2:0] wordIdx = avs_address[4:2];
    wire aligned = (avs_address[1:0] == 2'h0);
    wire permit = cpuRealMode | (cpuPrivLevel == dbu_pkg::PRIV_KERNEL);
    wire guard = controlReg[dbu_pkg::CT_GUARD];
    wire guardTrip = busAct & permit & guard;
    wire privDeny = busAct & ~permit;
    wire busOk = busAct & permit & ~guard;
    wire selStatus = aligned && (avs_address == dbu_pkg::ADDR_STATUS);
    wire selControl = aligned && (avs_address == dbu_pkg::ADDR_CONTROL);
    wire selBp = aligned && (wordIdx < 3'h4);
    wire wrOk = busOk & avs_write;

    assign ackNext = busReq & ~ackReg;
    assign avs_waitrequest = busReq & ~ackReg;
    assign avs_readdata = rdataReg;

    wire [31:0] readMux = selStatus ? (statusReg & dbu_pkg::STATUS_MASK)
                        : selControl ? (controlReg & dbu_pkg::CONTROL_MASK)
                        : selBp ? bpAddrReg[wordIdx[1:0]]
                        : 32'h0000_0000;
    assign rdataNext = (busReq & ~ackReg & permit & ~guard) ? readMux : 32'h0000_0000;

    // ====================================================
    // exception outputs and handler entry
    wire faultFire = instFault | guardTrip;
    wire handlerEntry = faultFire | trapFire;

    assign faultNext = faultFire;
    assign trapNext = trapFire;
    assign privNext = privDeny;
    assign excOut.fault = faultReg;
    assign excOut.trap = trapReg;
    assign excOut.privFault = privReg;

    // ====================================================
    // status: hardware only sets, set wins over software write
    wire [31:0] statusSet = ({28'h0, hitSet} << dbu_pkg::ST_HIT_LSB)
                          | ({31'h0, guardTrip} << dbu_pkg::ST_GUARD_BIT)
                          | ({31'h0, stepTrapFire} << dbu_pkg::ST_STEP_BIT)
                          | ({31'h0, switchTrapFire} << dbu_pkg::ST_SWITCH_BIT);
    wire [31:0] statusWr = laneMerge(statusReg, avs_writedata, avs_byteenable);
    assign statusNext = (((wrOk & selStatus) ? statusWr : statusReg)
                      | statusSet) & dbu_pkg::STATUS_MASK;

    // ====================================================
    // control: software write, then task switch and handler clears
    wire [31:0] controlWr = laneMerge(controlReg, avs_writedata, avs_byteenable);
    wire [31:0] controlSw = (wrOk & selControl) ? controlWr : controlReg;
    wire [31:0] switchClr = taskSwitch ? dbu_pkg::CONTROL_SWITCH_CLR : 32'h0000_0000;
    wire [31:0] guardClr = handlerEntry ? (32'h1 << dbu_pkg::CT_GUARD) : 32'h0000_0000;
    assign controlNext = controlSw & ~switchClr & ~guardClr & dbu_pkg::CONTROL_MASK;

    // ====================================================
    // registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            statusReg <= dbu_pkg::STATUS_RESET;
            controlReg <= dbu_pkg::CONTROL_RESET;
            ackReg <= 1'b0;
            rdataReg <= 32'h0000_0000;
            faultReg <= 1'b0;
            trapReg <= 1'b0;
            privReg <= 1'b0;
            dataPendReg <= 1'b0;
            stepPendReg <= 1'b0;
            retireWaitReg <= 1'b0;
            switchPendReg <= 1'b0;
        end
        else
        begin
            statusReg <= statusNext;
            controlReg <= controlNext;
            ackReg <= ackNext;
            rdataReg <= rdataNext;
            faultReg <= faultNext;
            trapReg <= trapNext;
            privReg <= privNext;
            dataPendReg <= dataPendNext;
            stepPendReg <= stepPendNext;
            retireWaitReg <= retireWaitNext;
            switchPendReg <= switchPendNext;
        end
    end

    // breakpoint address registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                bpAddrReg[i] <= 32'h0000_0000;
            end
        end
        else if (wrOk && selBp)
        begin
            bpAddrReg[wordIdx[1:0]] <= laneMerge(bpAddrReg[wordIdx[1:0]], avs_writedata,
                                                 avs_byteenable);
        end
    end

endmodule

/* dbu_pipe_model.sv */
// dbu pipe model: processor pipeline driving fetch, data, retire and switch
`timescale 1ns/1ps
module dbu_pipe_model (
    // clock
    input wire logic sys_clk,
    // pipeline events
    output dbu_pkg::dbu_fetch_s fetchIn,
    output dbu_pkg::dbu_data_s dataIn,
    output logic instRetire,
    output logic singleStepEnable,
    output logic dataXferBusy,
    output logic taskSwitch,
    output logic switchTrapBit
);
    initial
    begin
        fetchIn = '0;
        dataIn = '0;
        {instRetire, singleStepEnable, dataXferBusy, taskSwitch, switchTrapBit} = 5'h00;
    end
    task fetch(input logic [31:0] a, input logic r);
        @(posedge sys_clk);
        fetchIn <= '{1'b1, a, r};
        @(posedge sys_clk);
        fetchIn <= '{1'b0, ~a, ~r};
    endtask
    task access(input logic [29:0] d, input logic [3:0] l, input logic w);
        @(posedge sys_clk);
        dataIn <= '{1'b1, d, l, w};
        dataXferBusy <= 1'b1;
        @(posedge sys_clk);
        dataIn <= '{1'b0, ~d, ~l, ~w};
    endtask
    // busy: cycles the operand transfers outlast the retire
    task retire(input int busy, input logic step);
        @(posedge sys_clk);
        instRetire <= 1'b1;
        singleStepEnable <= step;
        dataXferBusy <= busy > 0;
        @(posedge sys_clk);
        instRetire <= 1'b0;
        singleStepEnable <= ~step;
        repeat (busy) @(posedge sys_clk);
        dataXferBusy <= 1'b0;
    endtask
    task switch_task(input logic t);
        @(posedge sys_clk);
        taskSwitch <= 1'b1;
        switchTrapBit <= t;
        @(posedge sys_clk);
        taskSwitch <= 1'b0;
        switchTrapBit <= ~t;
    endtask
endmodule

/* dbu_pkg.sv */
// debug breakpoint unit: constants, field layout and carrier types
package dbu_pkg;

    // ====================================================
    // register map, byte addresses
    localparam logic [4:0] ADDR_BP0 = 5'h00;
    localparam logic [4:0] ADDR_BP1 = 5'h04;
    localparam logic [4:0] ADDR_BP2 = 5'h08;
    localparam logic [4:0] ADDR_BP3 = 5'h0c;
    localparam logic [4:0] ADDR_STATUS = 5'h10;
    localparam logic [4:0] ADDR_CONTROL = 5'h14;

    // ====================================================
    // status fields
    localparam int ST_HIT_LSB = 0;
    localparam int ST_GUARD_BIT = 13;
    localparam int ST_STEP_BIT = 14;
    localparam int ST_SWITCH_BIT = 15;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_MASK = 32'h0000_e00f;

    // ====================================================
    // control fields
    localparam int CT_LOCAL_EN_LSB = 0;
    localparam int CT_GLOBAL_EN_LSB = 1;
    localparam int CT_LOCAL_EXACT = 8;
    localparam int CT_GLOBAL_EXACT = 9;
    localparam int CT_GUARD = 13;
    localparam int CT_QUAL_LSB = 16;
    localparam int CT_SIZE_LSB = 18;
    localparam int CT_BP_STRIDE = 4;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_MASK = 32'hffff_23ff;
    localparam logic [31:0] CONTROL_SWITCH_CLR = 32'h0000_0155;

    // ====================================================
    // field encodings
    localparam logic [1:0] QUAL_EXEC = 2'h0;
    localparam logic [1:0] QUAL_WRITE = 2'h1;
    localparam logic [1:0] QUAL_RW = 2'h3;
    localparam logic [1:0] SIZE_1 = 2'h0;
    localparam logic [1:0] SIZE_2 = 2'h1;
    localparam logic [1:0] SIZE_4 = 2'h3;
    localparam logic [1:0] PRIV_KERNEL = 2'h0;

    // ====================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic resume;
    } dbu_fetch_s;

    typedef struct packed {
        logic valid;
        logic [29:0] dwordAddr;
        logic [3:0] lanes;
        logic write;
    } dbu_data_s;

    typedef struct packed {
        logic fault;
        logic trap;
        logic privFault;
    } dbu_exc_s;

endpackage

/* tb_top.sv */
// tb_top: register and breakpoint tests of the debug breakpoint unit
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpuRealMode = 1'b1;
    logic [1:0] cpuPrivLevel = 2'h0;
    dbu_pkg::dbu_fetch_s fetchIn;
    dbu_pkg::dbu_data_s dataIn;
    dbu_pkg::dbu_exc_s excOut;
    logic instRetire, singleStepEnable, dataXferBusy, taskSwitch, switchTrapBit, stallNext;
    int errors = 0;
    int n_tests = 0;
    int nFault = 0, nTrap = 0, nPriv = 0, nStall = 0;
    logic [31:0] rd;
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        nFault <= nFault + int'(excOut.fault === 1'b1);
        nTrap <= nTrap + int'(excOut.trap === 1'b1);
        nPriv <= nPriv + int'(excOut.privFault === 1'b1);
        nStall <= nStall + int'(stallNext === 1'b1);
    end
    dbu_debug_breakpoint_unit u_dbu_debug_breakpoint_unit (.sys_clk, .resetn, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .cpuRealMode, .cpuPrivLevel, .fetchIn, .dataIn, .instRetire,
        .singleStepEnable, .dataXferBusy, .taskSwitch, .switchTrapBit, .excOut, .stallNext);
    dbu_pipe_model u_dbu_pipe_model (.sys_clk, .fetchIn, .dataIn, .instRetire,
        .singleStepEnable, .dataXferBusy, .taskSwitch, .switchTrapBit);
    task results();
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {!wr, wr, a, d, be};
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rd = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
    endtask
    task rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(name, rd, exp);
    endtask
    initial
    begin
        #100000;
        errors++;
        results();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        rd_chk("status reset", dbu_pkg::ADDR_STATUS, dbu_pkg::STATUS_RESET);
        rd_chk("control reset", dbu_pkg::ADDR_CONTROL, dbu_pkg::CONTROL_RESET);
        bus(1'b1, dbu_pkg::ADDR_BP0, 32'h0000_1000, 4'hf);
        bus(1'b1, dbu_pkg::ADDR_BP1, 32'h0000_1000, 4'hf);
        bus(1'b1, dbu_pkg::ADDR_CONTROL, 32'h0000_0001, 4'hf);
        u_dbu_pipe_model.fetch(32'h0000_1001, 1'b0);
        u_dbu_pipe_model.fetch(32'h0000_1000, 1'b1);
        repeat (3) @(posedge sys_clk);
        check("fault off match", nFault, 0);
        u_dbu_pipe_model.fetch(32'h0000_1000, 1'b0);
        u_dbu_pipe_model.fetch(32'h0000_2000, 1'b0);
        repeat (3) @(posedge sys_clk);
        check("exec fault", nFault, 1);
        rd_chk("exec hits", dbu_pkg::ADDR_STATUS, 32'h0000_0003);
        bus(1'b1, dbu_pkg::ADDR_STATUS, 32'h0, 4'hf);
        bus(1'b1, dbu_pkg::ADDR_BP2, 32'h0000_2004, 4'hf);
        bus(1'b1, dbu_pkg::ADDR_CONTROL, 32'h0500_0020, 4'hf);
        u_dbu_pipe_model.access(30'h0000_0801, 4'h2, 1'b0);
        u_dbu_pipe_model.retire(0, 1'b0);
        u_dbu_pipe_model.access(30'h0000_0801, 4'h8, 1'b1);
        u_dbu_pipe_model.retire(0, 1'b0);
        repeat (4) @(posedge sys_clk);
        check("no data trap", nTrap, 0);
        u_dbu_pipe_model.access(30'h0000_0801, 4'h2, 1'b1);
        u_dbu_pipe_model.retire(3, 1'b0);
        repeat (4) @(posedge sys_clk);
        check("data trap", nTrap, 1);
        check("stall", nStall, 4);
        rd_chk("data hit", dbu_pkg::ADDR_STATUS, 32'h0000_0004);
        bus(1'b1, dbu_pkg::ADDR_STATUS, 32'h0, 4'hf);
        u_dbu_pipe_model.retire(0, 1'b1);
        repeat (4) @(posedge sys_clk);
        check("step trap", nTrap, 2);
        rd_chk("step flag", dbu_pkg::ADDR_STATUS, 32'h0000_4000);
        bus(1'b1, dbu_pkg::ADDR_CONTROL, 32'hffff_03ff, 4'h3);
        u_dbu_pipe_model.switch_task(1'b1);
        repeat (4) @(posedge sys_clk);
        check("switch trap", nTrap, 3);
        rd_chk("switch ctrl", dbu_pkg::ADDR_CONTROL, 32'h0500_02aa);
        rd_chk("switch flag", dbu_pkg::ADDR_STATUS, 32'h0000_c000);
        bus(1'b1, dbu_pkg::ADDR_CONTROL, 32'h0000_2000, 4'hf);
        rd_chk("guarded read", dbu_pkg::ADDR_STATUS, 32'h0);
        repeat (3) @(posedge sys_clk);
        check("guard fault", nFault, 2);
        rd_chk("guard flag", dbu_pkg::ADDR_STATUS, 32'h0000_e000);
        rd_chk("guard clear", dbu_pkg::ADDR_CONTROL, 32'h0);
        cpuRealMode <= 1'b0;
        cpuPrivLevel <= 2'h3;
        rd_chk("denied read", dbu_pkg::ADDR_STATUS, 32'h0);
        cpuPrivLevel <= 2'h0;
        repeat (3) @(posedge sys_clk);
        check("priv fault", nPriv, 1);
        rd_chk("kernel read", dbu_pkg::ADDR_STATUS, 32'h0000_e000);
        rd_chk("unmapped", 5'h18, 32'h0);
        bus(1'b1, dbu_pkg::ADDR_BP3, 32'h0000_3003, 4'hf);
        bus(1'b1, dbu_pkg::ADDR_CONTROL, 32'h3000_0080, 4'hf);
        u_dbu_pipe_model.access(30'h0000_0c00, 4'h4, 1'b0);
        u_dbu_pipe_model.retire(0, 1'b0);
        repeat (3) @(posedge sys_clk);
        check("byte miss", nTrap, 3);
        u_dbu_pipe_model.access(30'h0000_0c00, 4'h8, 1'b0);
        u_dbu_pipe_model.retire(0, 1'b0);
        repeat (3) @(posedge sys_clk);
        check("read trap", nTrap, 4);
        bus(1'b1, dbu_pkg::ADDR_CONTROL, 32'hf000_0080, 4'hf);
        u_dbu_pipe_model.access(30'h0000_0c00, 4'h1, 1'b0);
        u_dbu_pipe_model.retire(0, 1'b0);
        repeat (3) @(posedge sys_clk);
        check("dword trap", nTrap, 5);
        rd_chk("read hit", dbu_pkg::ADDR_STATUS, 32'h0000_e008);
        results();
    end
endmodule
